// ---- rtl/ptpd_top.sv ----
// PTP per-port drop counters and egress detection config behind Avalon-MM
`timescale 1ns/1ns

// Behaviour
// - Each port counts ingress drops caused by a bad UDP checksum, 32 bits.
// - Each port counts ingress drops by PTP message filtering in another counter.
// - Every counted drop is also flagged as an error toward the receiving MAC.
// - Both drop counters stop at all ones instead of wrapping.
// - Counters reset to zero; software clears by writing zero.
// - Banked window: bank 1 holds drop counters, bank 2 egress parse config.
// - A two-bit port selector picks which port copy an access reaches.
// - Bit 14 (reset 1) detects layer-2 destination 01:80:C2:00:00:0E.
// - Bit 13 (reset 1) detects layer-2 destination 01:1B:19:00:00:00.
// - Bit 12 (reset 1) detects IPv4/IPv6 group address ending 129/181.
// - Bit 11 (reset 0) detects IPv4/IPv6 group address ending 130/182.
// - Bit 10 (reset 0) detects IPv4/IPv6 group address ending 131/183.
// - Bit 9 (reset 0) detects IPv4/IPv6 group address ending 132/184.
// - Bit 8 (reset 1) detects 224.0.0.107 and FF02::6B with their MACs.
// - Bit 7 (reset 0) detects layer-2 frames to the software MAC.
// - Bit 6 (reset 0) detects IPv6 frames to the software MAC.
// - Bit 5 (reset 0) detects IPv4 frames to the software MAC.
module ptpd_top
    import ptpd_pkg::*;
#(
    parameter int NPORTS = `PTPD_NPORTS
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [`PTPD_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Ingress drop events, one pulse per dropped packet
    input wire logic [NPORTS-1:0] rx_csum_drop,
    input wire logic [NPORTS-1:0] rx_filter_drop,
    output logic [NPORTS-1:0] rx_mac_error,
    // Egress frame headers
    input wire logic [NPORTS-1:0] tx_frame_valid,
    input wire logic [NPORTS-1:0][1:0] tx_frame_kind,
    input wire logic [NPORTS-1:0][47:0] tx_dst_mac,
    input wire logic [NPORTS-1:0][127:0] tx_dst_ip,
    output logic [NPORTS-1:0] tx_ptp_hit,
    output logic [NPORTS-1:0] tx_ptp_done,
    // Interrupt
    output logic irq
);

    ptpd_state_s s_q;
    ptpd_state_s s_d;
    logic accept;
    logic wr_go;
    logic [31:0] rd_mux;
    logic [NPORTS-1:0] csum_wr;
    logic [NPORTS-1:0] filt_wr;
    logic [NPORTS-1:0] txcfg_wr;
    logic [`PTPD_IRQ_W-1:0] events;

    function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
                r[8*b +: 8] = wd[8*b +: 8];
        end
        return r;
    endfunction : f_merge

    // ****************************************
    // Read multiplexer
    // ****************************************
    always_comb
    begin
        rd_mux = 32'h0;
        unique case (address)
            `PTPD_OFS_SELECT:
                rd_mux = {26'h0, s_q.port, 1'b0, s_q.bank};
            `PTPD_OFS_IRQ_STATUS:
                rd_mux = {29'h0, s_q.ist};
            `PTPD_OFS_IRQ_ENABLE:
                rd_mux = {29'h0, s_q.ien};
            `PTPD_OFS_MAC_HIGH:
                rd_mux = {16'h0, s_q.umac[47:32]};
            `PTPD_OFS_MAC_LOW:
                rd_mux = s_q.umac[31:0];
            default:
                rd_mux = 32'h0;
        endcase
        for (int i = 0; i < NPORTS; i++)
        begin
            if (s_q.port == 2'(i))
            begin
                if (s_q.bank == `PTPD_BANK_RX && address == `PTPD_OFS_CSUM_DROP)
                    rd_mux = s_q.csum_cnt[i];
                if (s_q.bank == `PTPD_BANK_RX && address == `PTPD_OFS_FILT_DROP)
                    rd_mux = s_q.filt_cnt[i];
                if (s_q.bank == `PTPD_BANK_TX && address == `PTPD_OFS_TX_PARSE)
                    rd_mux = {17'h0, s_q.txcfg[i]};
            end
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        accept = (read || write) && !s_q.ack;
        wr_go = write && s_q.ack;
        events = '0;
        s_d.ack = accept;
        if (accept && read)
            s_d.rdata = rd_mux;
        if (wr_go)
        begin
            unique case (address)
                `PTPD_OFS_SELECT:
                    if (byteenable[0])
                    begin
                        s_d.bank = writedata[`PTPD_SEL_BANK_LSB +: 3];
                        s_d.port = writedata[`PTPD_SEL_PORT_LSB +: 2];
                    end
                `PTPD_OFS_IRQ_ENABLE:
                    if (byteenable[0])
                        s_d.ien = writedata[`PTPD_IRQ_W-1:0];
                `PTPD_OFS_IRQ_CLEAR:
                    if (byteenable[0])
                        s_d.ist = s_q.ist & ~writedata[`PTPD_IRQ_W-1:0];
                `PTPD_OFS_MAC_HIGH:
                    s_d.umac[47:32] = 16'(f_merge({16'h0, s_q.umac[47:32]}, writedata,
                                                  byteenable));
                `PTPD_OFS_MAC_LOW:
                    s_d.umac[31:0] = f_merge(s_q.umac[31:0], writedata, byteenable);
                default:
                    s_d.umac = s_q.umac;
            endcase
        end
        for (int i = 0; i < NPORTS; i++)
        begin
            csum_wr[i] = wr_go && s_q.port == 2'(i) && s_q.bank == `PTPD_BANK_RX
                && address == `PTPD_OFS_CSUM_DROP;
            filt_wr[i] = wr_go && s_q.port == 2'(i) && s_q.bank == `PTPD_BANK_RX
                && address == `PTPD_OFS_FILT_DROP;
            txcfg_wr[i] = wr_go && s_q.port == 2'(i) && s_q.bank == `PTPD_BANK_TX
                && address == `PTPD_OFS_TX_PARSE;
            if (csum_wr[i])
                s_d.csum_cnt[i] = f_merge(s_q.csum_cnt[i], writedata, byteenable);
            if (filt_wr[i])
                s_d.filt_cnt[i] = f_merge(s_q.filt_cnt[i], writedata, byteenable);
            if (txcfg_wr[i])
                s_d.txcfg[i] = (s_q.txcfg[i] & ~`PTPD_TXCFG_WMASK)
                    | (`PTPD_TXCFG_W'(f_merge({17'h0, s_q.txcfg[i]}, writedata, byteenable))
                       & `PTPD_TXCFG_WMASK);
            // A drop in the cycle of a clearing write still counts
            if (rx_csum_drop[i] && s_d.csum_cnt[i] != `PTPD_CNT_MAX)
            begin
                s_d.csum_cnt[i] = s_d.csum_cnt[i] + 32'h1;
                if (s_d.csum_cnt[i] == `PTPD_CNT_MAX)
                    events[`PTPD_IRQ_CSUM_MAX] = 1'b1;
            end
            if (rx_filter_drop[i] && s_d.filt_cnt[i] != `PTPD_CNT_MAX)
            begin
                s_d.filt_cnt[i] = s_d.filt_cnt[i] + 32'h1;
                if (s_d.filt_cnt[i] == `PTPD_CNT_MAX)
                    events[`PTPD_IRQ_FILT_MAX] = 1'b1;
            end
            s_d.mac_err[i] = rx_csum_drop[i] || rx_filter_drop[i];
            if (tx_ptp_hit[i])
                events[`PTPD_IRQ_TX_PTP] = 1'b1;
        end
        // Hardware set wins over a same-cycle clear
        s_d.ist = s_d.ist | events;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            for (int i = 0; i < `PTPD_NPORTS; i++)
            begin
                s_q.csum_cnt[i] <= `PTPD_CNT_RESET;
                s_q.filt_cnt[i] <= `PTPD_CNT_RESET;
                s_q.txcfg[i] <= `PTPD_TXCFG_RESET;
            end
        end
        else
            s_q <= s_d;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign waitrequest = (read || write) && !s_q.ack;
    assign readdata = s_q.rdata;
    assign rx_mac_error = s_q.mac_err;
    assign irq = |(s_q.ist & s_q.ien);

    // ****************************************
    // Egress matchers
    // ****************************************
    generate
        for (genvar g = 0; g < NPORTS; g++)
        begin : g_match
            ptpd_match u_match (
                .clk(clk),
                .reset_n(reset_n),
                .cfg(s_q.txcfg[g]),
                .user_mac(s_q.umac),
                .frame_valid(tx_frame_valid[g]),
                .frame_kind(tx_frame_kind[g]),
                .dst_mac(tx_dst_mac[g]),
                .dst_ip(tx_dst_ip[g]),
                .ptp_hit(tx_ptp_hit[g]),
                .ptp_done(tx_ptp_done[g])
            );
        end
    endgenerate

    // ****************************************
    // Checks
    // ****************************************
    generate
        for (genvar g = 0; g < NPORTS; g++)
        begin : g_chk
            property p_csum_inc;
                @(posedge clk) disable iff (!reset_n)
                rx_csum_drop[g] && !csum_wr[g] && s_q.csum_cnt[g] != `PTPD_CNT_MAX
                    |=> s_q.csum_cnt[g] == $past(s_q.csum_cnt[g]) + 32'h1;
            endproperty
            a_csum_inc: assert property (p_csum_inc) else $error("checksum count missed");

            property p_filt_inc;
                @(posedge clk) disable iff (!reset_n)
                rx_filter_drop[g] && !filt_wr[g] && s_q.filt_cnt[g] != `PTPD_CNT_MAX
                    |=> s_q.filt_cnt[g] == $past(s_q.filt_cnt[g]) + 32'h1;
            endproperty
            a_filt_inc: assert property (p_filt_inc) else $error("filter count missed");

            property p_mac_err;
                @(posedge clk) disable iff (!reset_n)
                rx_csum_drop[g] || rx_filter_drop[g] |=> rx_mac_error[g];
            endproperty
            a_mac_err: assert property (p_mac_err) else $error("drop not flagged to MAC");

            property p_saturate;
                @(posedge clk) disable iff (!reset_n)
                s_q.csum_cnt[g] == `PTPD_CNT_MAX && !csum_wr[g]
                    |=> s_q.csum_cnt[g] == `PTPD_CNT_MAX;
            endproperty
            a_saturate: assert property (p_saturate) else $error("counter wrapped");

            property p_clear;
                @(posedge clk) disable iff (!reset_n)
                csum_wr[g] && writedata == 32'h0 && byteenable == 4'hF && !rx_csum_drop[g]
                    |=> s_q.csum_cnt[g] == 32'h0;
            endproperty
            a_clear: assert property (p_clear) else $error("zero write did not clear");
        end
    endgenerate

    property p_answer;
        @(posedge clk) disable iff (!reset_n)
        (read || write) && waitrequest |=> !waitrequest || !(read || write);
    endproperty
    a_answer: assert property (p_answer) else $error("slave stalled over one cycle");

    property p_bank_read;
        @(posedge clk) disable iff (!reset_n)
        read && waitrequest && s_q.bank == `PTPD_BANK_RX && s_q.port == 2'h0
            && address == `PTPD_OFS_CSUM_DROP
            |=> readdata == $past(s_q.csum_cnt[0]);
    endproperty
    a_bank_read: assert property (p_bank_read) else $error("banked read wrong");

    property p_rsvd_zero;
        @(posedge clk) disable iff (!reset_n)
        read && waitrequest && s_q.bank == `PTPD_BANK_TX && address == `PTPD_OFS_TX_PARSE
            |=> readdata[31:15] == 17'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

    property p_irq_tx;
        @(posedge clk) disable iff (!reset_n)
        tx_ptp_hit[0] && s_q.ien[`PTPD_IRQ_TX_PTP] |=> irq;
    endproperty
    a_irq_tx: assert property (p_irq_tx) else $error("interrupt not raised");

endmodule : ptpd_top

// ---- shared/ptpd_defs.svh ----
// Offsets, field positions, reset values and match constants of the PTP port block
`ifndef PTPD_DEFS_SVH
`define PTPD_DEFS_SVH

// ****************************************
// Geometry
// ****************************************
`define PTPD_NPORTS 3
`define PTPD_ADDR_W 9

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PTPD_OFS_SELECT 9'h100
`define PTPD_OFS_IRQ_STATUS 9'h104
`define PTPD_OFS_IRQ_ENABLE 9'h108
`define PTPD_OFS_IRQ_CLEAR 9'h10C
`define PTPD_OFS_MAC_HIGH 9'h110
`define PTPD_OFS_MAC_LOW 9'h114
`define PTPD_OFS_TX_PARSE 9'h158
`define PTPD_OFS_CSUM_DROP 9'h188
`define PTPD_OFS_FILT_DROP 9'h18C

// ****************************************
// Banks and fields
// ****************************************
`define PTPD_BANK_RX 3'h1
`define PTPD_BANK_TX 3'h2
`define PTPD_SEL_BANK_LSB 0
`define PTPD_SEL_PORT_LSB 4
`define PTPD_TXCFG_W 15
`define PTPD_TXCFG_RESET 15'h7100
`define PTPD_TXCFG_WMASK 15'h7FE0
`define PTPD_BIT_L2_A 14
`define PTPD_BIT_L2_B 13
`define PTPD_BIT_IP_FIRST 12
`define PTPD_BIT_L2_USER 7
`define PTPD_BIT_V6_USER 6
`define PTPD_BIT_V4_USER 5
`define PTPD_CNT_RESET 32'h00000000
`define PTPD_CNT_MAX 32'hFFFFFFFF

// ****************************************
// Interrupt status bits
// ****************************************
`define PTPD_IRQ_W 3
`define PTPD_IRQ_CSUM_MAX 0
`define PTPD_IRQ_FILT_MAX 1
`define PTPD_IRQ_TX_PTP 2

// ****************************************
// Destination addresses
// ****************************************
`define PTPD_MAC_L2_A 48'h0180C200000E
`define PTPD_MAC_L2_B 48'h011B19000000
`define PTPD_MAC_V4_PREFIX 32'h01005E00
`define PTPD_MAC_V6_PREFIX 32'h33330000
`define PTPD_IP_V4_PREFIX 16'hE000
`define PTPD_IP_V6_HEAD 8'hFF
`define PTPD_IP_V6_LINK 16'hFF02
`define PTPD_IP_NENTRY 5
`define PTPD_IP_LOW_6B 16'h006B
`define PTPD_IP_ENTRIES {16'h006B, 16'h0184, 16'h0183, 16'h0182, 16'h0181}

`endif

// ---- shared/ptpd_pkg.sv ----
// Types of the PTP port block
package ptpd_pkg;

    `include "ptpd_defs.svh"

    // ****************************************
    // Frame kinds seen on the egress path
    // ****************************************
    typedef enum logic [1:0] {
        PTPD_KIND_L2,
        PTPD_KIND_IPV4,
        PTPD_KIND_IPV6
    } ptpd_kind_e;

    // ****************************************
    // Matcher state
    // ****************************************
    typedef struct packed {
        logic hit;
        logic done;
    } ptpd_match_s;

    // ****************************************
    // Main block state
    // ****************************************
    typedef struct packed {
        logic [2:0] bank;
        logic [1:0] port;
        logic [`PTPD_NPORTS-1:0][31:0] csum_cnt;
        logic [`PTPD_NPORTS-1:0][31:0] filt_cnt;
        logic [`PTPD_NPORTS-1:0][`PTPD_TXCFG_W-1:0] txcfg;
        logic [47:0] umac;
        logic [`PTPD_IRQ_W-1:0] ist;
        logic [`PTPD_IRQ_W-1:0] ien;
        logic ack;
        logic [31:0] rdata;
        logic [`PTPD_NPORTS-1:0] mac_err;
    } ptpd_state_s;

endpackage : ptpd_pkg

// ---- rtl/ptpd_match.sv ----
// Egress PTP destination address matcher for one port
`timescale 1ns/1ns

module ptpd_match
    import ptpd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Configuration
    input wire logic [`PTPD_TXCFG_W-1:0] cfg,
    input wire logic [47:0] user_mac,
    // Frame header
    input wire logic frame_valid,
    input wire logic [1:0] frame_kind,
    input wire logic [47:0] dst_mac,
    input wire logic [127:0] dst_ip,
    // Result
    output logic ptp_hit,
    output logic ptp_done
);

    localparam logic [`PTPD_IP_NENTRY-1:0][15:0] ENTRIES = `PTPD_IP_ENTRIES;

    ptpd_match_s s_q;
    ptpd_match_s s_d;
    logic match;
    logic v6_ip_ok;

    // ****************************************
    // Address compare
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        match = 1'b0;
        v6_ip_ok = 1'b0;
        unique case (ptpd_kind_e'(frame_kind))
            PTPD_KIND_L2:
            begin
                if (cfg[`PTPD_BIT_L2_A] && dst_mac == `PTPD_MAC_L2_A)
                    match = 1'b1;
                if (cfg[`PTPD_BIT_L2_B] && dst_mac == `PTPD_MAC_L2_B)
                    match = 1'b1;
                if (cfg[`PTPD_BIT_L2_USER] && dst_mac == user_mac)
                    match = 1'b1;
            end
            PTPD_KIND_IPV4:
            begin
                for (int k = 0; k < `PTPD_IP_NENTRY; k++)
                begin
                    if (cfg[`PTPD_BIT_IP_FIRST-k]
                        && dst_mac == {`PTPD_MAC_V4_PREFIX, ENTRIES[k]}
                        && dst_ip[31:0] == {`PTPD_IP_V4_PREFIX, ENTRIES[k]})
                        match = 1'b1;
                end
                if (cfg[`PTPD_BIT_V4_USER] && dst_mac == user_mac)
                    match = 1'b1;
            end
            PTPD_KIND_IPV6:
            begin
                for (int k = 0; k < `PTPD_IP_NENTRY; k++)
                begin
                    if (ENTRIES[k] == `PTPD_IP_LOW_6B)
                        v6_ip_ok = dst_ip[127:112] == `PTPD_IP_V6_LINK;
                    else
                        v6_ip_ok = dst_ip[127:120] == `PTPD_IP_V6_HEAD
                            && dst_ip[119:116] == 4'h0;
                    if (cfg[`PTPD_BIT_IP_FIRST-k] && v6_ip_ok
                        && dst_ip[111:16] == 96'h0 && dst_ip[15:0] == ENTRIES[k]
                        && dst_mac == {`PTPD_MAC_V6_PREFIX, ENTRIES[k]})
                        match = 1'b1;
                end
                if (cfg[`PTPD_BIT_V6_USER] && dst_mac == user_mac)
                    match = 1'b1;
            end
            default:
                match = 1'b0;
        endcase
        s_d.done = frame_valid;
        s_d.hit = frame_valid && match;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign ptp_hit = s_q.hit;
    assign ptp_done = s_q.done;

    // ****************************************
    // Checks
    // ****************************************
    property p_l2_a_hit;
        @(posedge clk) disable iff (!reset_n)
        frame_valid && frame_kind == 2'(PTPD_KIND_L2) && dst_mac == `PTPD_MAC_L2_A
            && cfg[`PTPD_BIT_L2_A] |=> ptp_hit && ptp_done;
    endproperty
    a_l2_a_hit: assert property (p_l2_a_hit) else $error("fixed L2 address not detected");

    property p_all_off;
        @(posedge clk) disable iff (!reset_n)
        frame_valid && cfg == '0 |=> !ptp_hit;
    endproperty
    a_all_off: assert property (p_all_off) else $error("hit with every entry disabled");

endmodule : ptpd_match

// ---- verif/ptpd_mac_model.sv ----
// Model of the port MAC paths: ingress drop events and egress headers
`timescale 1ns/1ns

module ptpd_mac_model
(
    // Clock
    input wire logic clk,
    // Ingress drop events
    output logic [2:0] rx_csum_drop,
    output logic [2:0] rx_filter_drop,
    // Egress headers
    output logic [2:0] tx_frame_valid,
    output logic [2:0][1:0] tx_frame_kind,
    output logic [2:0][47:0] tx_dst_mac,
    output logic [2:0][127:0] tx_dst_ip
);
    initial
    begin
        rx_csum_drop = 3'h0;
        rx_filter_drop = 3'h0;
        tx_frame_valid = 3'h0;
        tx_frame_kind = '0;
        tx_dst_mac = '0;
        tx_dst_ip = '0;
    end

    // One cycle of drop pulses
    task automatic drops(input logic [2:0] c, input logic [2:0] f);
        @(posedge clk);
        rx_csum_drop <= c;
        rx_filter_drop <= f;
        @(posedge clk);
        rx_csum_drop <= 3'h0;
        rx_filter_drop <= 3'h0;
    endtask : drops

    // One header; fields scrambled once released
    task automatic frame(input int p, input logic [1:0] k, input logic [47:0] m,
                         input logic [127:0] ip);
        @(posedge clk);
        tx_frame_valid[p] <= 1'b1;
        tx_frame_kind[p] <= k;
        tx_dst_mac[p] <= m;
        tx_dst_ip[p] <= ip;
        @(posedge clk);
        tx_frame_valid <= 3'h0;
        tx_frame_kind[p] <= ~k;
        tx_dst_mac[p] <= ~m;
        tx_dst_ip[p] <= ~ip;
    endtask : frame
endmodule : ptpd_mac_model

// ---- verif/tb.sv ----
// Self-checking bench of the PTP port block
`timescale 1ns/1ns
`include "ptpd_defs.svh"

module tb;
    logic clk, reset_n, read, write, waitrequest, irq;
    logic [8:0] address;
    logic [31:0] writedata, readdata, rdata, rnd;
    logic [3:0] byteenable;
    logic [2:0] rx_csum_drop, rx_filter_drop, rx_mac_error, tx_frame_valid;
    logic [2:0] tx_ptp_hit, tx_ptp_done;
    logic [2:0][1:0] tx_frame_kind;
    logic [2:0][47:0] tx_dst_mac;
    logic [2:0][127:0] tx_dst_ip;
    logic [47:0] umac;
    logic [31:0] csum_m[3], filt_m[3];
    int fail_count, checks_done;

    ptpd_top ptpd_top_inst (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .rx_csum_drop(rx_csum_drop),
        .rx_filter_drop(rx_filter_drop), .rx_mac_error(rx_mac_error),
        .tx_frame_valid(tx_frame_valid), .tx_frame_kind(tx_frame_kind),
        .tx_dst_mac(tx_dst_mac), .tx_dst_ip(tx_dst_ip), .tx_ptp_hit(tx_ptp_hit),
        .tx_ptp_done(tx_ptp_done), .irq(irq));
    ptpd_mac_model ptpd_mac_model_inst (.clk(clk), .rx_csum_drop(rx_csum_drop),
        .rx_filter_drop(rx_filter_drop), .tx_frame_valid(tx_frame_valid),
        .tx_frame_kind(tx_frame_kind), .tx_dst_mac(tx_dst_mac), .tx_dst_ip(tx_dst_ip));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ******************
    // Helpers
    // ******************
    task automatic tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Avalon transfer held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do
        begin
            @(posedge clk);
            n++;
            if (n > 20)
            begin
                fail_count++;
                tally_and_finish();
            end
        end
        while (waitrequest !== 1'b0);
        rdata = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic sel(input logic [2:0] bank, input logic [1:0] port);
        bus(1'b1, `PTPD_OFS_SELECT, {26'h0, port, 1'b0, bank});
    endtask : sel

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Headers aimed at the address of enable bit e
    task automatic mk(input int e, input int k, output logic [47:0] m, output logic [127:0] ip);
        logic [15:0] lo;
        lo = (e == 8) ? 16'h006B : {8'h01, 8'h81 + 8'(12 - e)};
        if (e == 14)
            m = 48'h0180C200000E;
        else if (e == 13)
            m = 48'h011B19000000;
        else if (e <= 7)
            m = umac;
        else
            m = (k == 2) ? {32'h33330000, lo} : {32'h01005E00, lo};
        ip = (k == 2) ? {8'hFF, (e == 8) ? 8'h02 : 8'h05, 96'h0, lo} : {96'h0, 16'hE000, lo};
    endtask : mk

    function automatic logic hit_exp(input int b, input int e, input int k);
        int want;
        want = (b == 7 || b >= 13) ? 0 : (b == 6) ? 2 : (b == 5) ? 1 : -1;
        if (!(e == b || (e <= 7 && b <= 7)))
            return 1'b0;
        return (want < 0) ? (k == 1 || k == 2) : (k == want);
    endfunction : hit_exp

    // ******************
    // Main sequence
    // ******************
    initial
    begin
        int p, b, e, k, i;
        logic [47:0] m;
        logic [127:0] ip;
        reset_n = 1'b0;
        {read, write, address, writedata} = '0;
        byteenable = 4'hF;
        rnd = 32'h00011044;
        fail_count = 0;
        checks_done = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        for (p = 0; p < 3; p++)
        begin
            csum_m[p] = 32'h0;
            filt_m[p] = 32'h0;
            sel(3'h2, p[1:0]);
            bus(1'b0, `PTPD_OFS_TX_PARSE, 32'h0);
            check("parse reset", rdata, 32'h00007100);
        end
        $display("reset values done");
        for (i = 0; i < 40; i++)
        begin
            rnd = lfsr(rnd);
            ptpd_mac_model_inst.drops(rnd[2:0], rnd[5:3]);
            #1;
            check("mac error", {29'h0, rx_mac_error}, {29'h0, rnd[2:0] | rnd[5:3]});
            for (p = 0; p < 3; p++)
            begin
                csum_m[p] += rnd[p];
                filt_m[p] += rnd[p + 3];
            end
        end
        for (p = 0; p < 4; p++)
        begin
            sel(3'h1, p[1:0]);
            bus(1'b0, `PTPD_OFS_CSUM_DROP, 32'h0);
            check("csum count", rdata, (p < 3) ? csum_m[p] : 32'h0);
            bus(1'b0, `PTPD_OFS_FILT_DROP, 32'h0);
            check("filter count", rdata, (p < 3) ? filt_m[p] : 32'h0);
        end
        $display("drop counting done");
        sel(3'h1, 2'h1);
        bus(1'b1, `PTPD_OFS_CSUM_DROP, 32'hFFFFFFFE);
        bus(1'b1, `PTPD_OFS_FILT_DROP, 32'hFFFFFFFE);
        repeat (2) ptpd_mac_model_inst.drops(3'h2, 3'h2);
        bus(1'b0, `PTPD_OFS_CSUM_DROP, 32'h0);
        check("csum max", rdata, 32'hFFFFFFFF);
        bus(1'b0, `PTPD_OFS_FILT_DROP, 32'h0);
        check("filter max", rdata, 32'hFFFFFFFF);
        bus(1'b0, `PTPD_OFS_IRQ_STATUS, 32'h0);
        check("max status", rdata, 32'h3);
        bus(1'b1, `PTPD_OFS_IRQ_ENABLE, 32'h0);
        #1 check("irq masked", {31'h0, irq}, 32'h0);
        bus(1'b1, `PTPD_OFS_IRQ_ENABLE, 32'h1);
        #1 check("irq raised", {31'h0, irq}, 32'h1);
        bus(1'b1, `PTPD_OFS_IRQ_CLEAR, 32'h3);
        #1 check("irq cleared", {31'h0, irq}, 32'h0);
        bus(1'b1, `PTPD_OFS_CSUM_DROP, 32'h0);
        bus(1'b0, `PTPD_OFS_CSUM_DROP, 32'h0);
        check("csum cleared", rdata, 32'h0);
        bus(1'b0, 9'h0FC, 32'h0);
        check("unmapped", rdata, 32'h0);
        $display("saturation and interrupt done");

        // ******************
        // Egress detection sweep
        // ******************
        rnd = lfsr(rnd);
        umac = {rnd[15:0], lfsr(rnd)};
        bus(1'b1, `PTPD_OFS_MAC_HIGH, {16'h0, umac[47:32]});
        bus(1'b1, `PTPD_OFS_MAC_LOW, umac[31:0]);
        sel(3'h2, 2'h0);
        bus(1'b1, `PTPD_OFS_TX_PARSE, 32'hFFFFFFFF);
        bus(1'b0, `PTPD_OFS_TX_PARSE, 32'h0);
        check("parse fields", rdata, 32'h00007FE0);
        bus(1'b1, `PTPD_OFS_IRQ_ENABLE, 32'h4);
        for (b = 5; b < 15; b++)
        begin
            p = b % 3;
            sel(3'h2, p[1:0]);
            // Enables change only while no header is valid
            bus(1'b1, `PTPD_OFS_TX_PARSE, 32'h1 << b);
            for (e = 5; e < 15; e++)
                for (k = 0; k < 4; k++)
                begin
                    mk(e, k, m, ip);
                    ptpd_mac_model_inst.frame(p, k[1:0], m, ip);
                    #1;
                    check("ptp hit", {30'h0, tx_ptp_done[p], tx_ptp_hit[p]},
                          {30'h0, 1'b1, hit_exp(b, e, k)});
                end
        end
        for (p = 0; p < 3; p++)
        begin
            sel(3'h2, p[1:0]);
            bus(1'b0, `PTPD_OFS_TX_PARSE, 32'h0);
            check("parse per port", rdata, 32'h1 << (12 + p));
        end
        bus(1'b1, `PTPD_OFS_IRQ_ENABLE, 32'h4);
        #1 check("irq on detect", {31'h0, irq}, 32'h1);
        bus(1'b1, `PTPD_OFS_IRQ_CLEAR, 32'h4);
        #1 check("irq detect cleared", {31'h0, irq}, 32'h0);
        $display("egress detection done");
        tally_and_finish();
    end
endmodule : tb
